// File: design/acc_pkg.sv
// Package for the converter control block: register map, fields, timing.
// Assumes a byte-wide register port clocked by CLK_SYS.
`default_nettype none
package acc_pkg;
  // Register offsets (byte-wide registers, one per address)
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] ADDR_RES_HI = 4'h2;
  localparam logic [3:0] ADDR_RES_LO = 4'h3;
  localparam logic [3:0] ADDR_ASEL_LO = 4'h4;
  localparam logic [3:0] ADDR_ASEL_HI = 4'h5;
  localparam logic [3:0] ADDR_DIR_LO = 4'h6;
  localparam logic [3:0] ADDR_DIR_HI = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_INT_EN = 4'h9;
  // Control 0 fields
  localparam int CTRL0_JUSTIFY = 7;
  localparam int CTRL0_REFSEL = 6;
  localparam int CTRL0_CHAN_HI = 5;
  localparam int CTRL0_CHAN_LO = 2;
  localparam int CTRL0_GO = 1;
  localparam int CTRL0_ON = 0;
  // Control 1 fields
  localparam int CTRL1_CS_HI = 6;
  localparam int CTRL1_CS_LO = 4;
  // Reset values
  localparam logic [7:0] ASEL_LO_RST = 8'hFF;
  localparam logic [3:0] ASEL_HI_RST = 4'hF;
  localparam logic [7:0] DIR_LO_RST = 8'hFF;
  localparam logic [3:0] DIR_HI_RST = 4'hF;
  // Clock-select codes
  localparam logic [2:0] CS_DIV2 = 3'h0;
  localparam logic [2:0] CS_DIV8 = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV4 = 3'h4;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  // Sequence timing in bit periods, then resolution, pin and channel counts
  localparam logic [3:0] CONV_PERIODS = 4'hB;
  localparam logic [3:0] ABORT_PERIODS = 4'h2;
  localparam int RES_BITS = 10;
  localparam int NUM_PINS = 12;
  localparam int NUM_CHAN = 14;
  // Clock rate and least bit period, for reference by software
  localparam int CLK_MHZ = 40;
  localparam int MIN_TAD_NS = 1600;
  localparam int MIN_TAD_CYC = (MIN_TAD_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_ACQ = 4'b1000
  } acc_state_t;
endpackage : acc_pkg
`default_nettype wire

// File: design/acc_tick.sv
// Conversion bit-period tick generator: divides the system clock or
// resynchronises the internal RC oscillator edge into one-cycle ticks.
// Assumes RC_CLK is a synchronous level at CLK_SYS.
`default_nettype none
module acc_tick (
  input wire logic CLK_SYS, // System clock
  input wire logic RST_N, // Async reset, active low
  input wire logic [2:0] SEL, // Latched clock select
  input wire logic RUN, // Counting enabled
  input wire logic RC_CLK, // Internal RC oscillator level
  output logic TICK // One pulse per bit period
);
  import acc_pkg::*;
  typedef struct packed {
    logic [5:0] cnt;
    logic rc_d;
  } acc_tick_st_t;
  acc_tick_st_t cur_ff, nxt_st;
  logic [5:0] last;
  always_comb begin
    case (SEL)
      CS_DIV2: last = 6'h01;
      CS_DIV4: last = 6'h03;
      CS_DIV8: last = 6'h07;
      CS_DIV16: last = 6'h0F;
      CS_DIV32: last = 6'h1F;
      CS_DIV64: last = 6'h3F;
      default: last = 6'h00;
    endcase
  end
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.rc_d = RC_CLK;
    TICK = 1'b0;
    if (!RUN) begin
      nxt_st.cnt = 6'h00;
    end else if (SEL[1:0] == 2'b11) begin
      TICK = RC_CLK && !cur_ff.rc_d;
    end else if (cur_ff.cnt == last) begin
      TICK = 1'b1;
      nxt_st.cnt = 6'h00;
    end else begin
      nxt_st.cnt = cur_ff.cnt + 6'h01;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end
  property p_div2;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (RUN && SEL == CS_DIV2 && TICK) ##1 (RUN && SEL == CS_DIV2)
        |-> !TICK ##1 (!RUN || TICK);
  endproperty
  a_div2: assert property (p_div2) else $error("div2 tick lost");
endmodule // acc_tick
`default_nettype wire

// File: design/acc_top.sv
// Converter control block: registers, channel/reference routing, sequencer.
// Assumes a synchronous register port and a SAR comparator input.
`default_nettype none
// What this block does
// - A conversion lasts eleven ticks: exactly eleven periods when divided, ten and part of one with RC.
// - Bit clock is oscillator divided by 2..64 or internal RC.
// - Codes 000, 100, 001 give 2, 4, 8 oscillator periods.
// - Codes 101 and 010 give 16 and 32 oscillator periods.
// - Reference select one uses external pin, zero uses supply.
// - Four-bit channel field picks one of fourteen channels.
// - Twelve pins and two internal inputs share one sample-hold.
// - Successive approximation result stored in a 10-bit register.
// - Analog-select bit disables that pin's digital input buffer.
// - Direction bit one puts that pin's driver in high impedance.
// - Twelve analog bits split eight low, four high, reset to one.
// - Go starts conversion; done clears go, sets flag, interrupts.
// - Abort keeps old result; reacquire after two bit periods.
// - Justify one right-justifies result, zero left-justifies.
module acc_top (
  input wire logic CLK_SYS, // System clock, 40 MHz
  input wire logic RST_N, // Async reset, active low
  input wire logic [3:0] ADDR, // Register address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [7:0] RDATA, // Read data, cycle after RD
  input wire logic RC_CLK, // Internal RC oscillator level
  input wire logic CMP_IN, // SAR comparator: sample above DAC
  output logic [9:0] DAC_CODE, // Trial code to the DAC
  output logic [3:0] MUX_SEL, // Channel routed to sample-hold
  output logic REF_EXT, // 1 = external reference pin
  output logic SAMPLE, // Sample-hold tracking input
  output logic [11:0] DIG_IN_EN, // Digital input buffer enables
  output logic [11:0] PIN_OE, // Pin output driver enables
  output logic IRQ // Conversion-done interrupt level
);
  import acc_pkg::*;
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic justify;
    logic ref_sel;
    logic [3:0] chan;
    logic go;
    logic on;
    logic [2:0] cs;
    logic [7:0] asel_lo;
    logic [3:0] asel_hi;
    logic [7:0] dir_lo;
    logic [3:0] dir_hi;
    logic done_flag;
    logic int_en;
    logic [9:0] result;
    logic [9:0] sar;
    logic [3:0] bitn;
    logic [3:0] per;
    logic [3:0] l_chan;
    logic l_ref;
    logic [2:0] l_cs;
    acc_state_t st;
    logic [7:0] rdata;
  } acc_st_t;
  acc_st_t cur_ff, nxt_st;
  logic tick;
  logic run;
  logic [11:0] asel;
  logic [11:0] dir;
  logic [9:0] trial;
  logic [9:0] kept;
  assign asel = {cur_ff.asel_hi, cur_ff.asel_lo};
  assign dir = {cur_ff.dir_hi, cur_ff.dir_lo};
  assign run = (cur_ff.st == ST_CONV) || (cur_ff.st == ST_WAIT);
  // ------------------------------------------------------------
  // Bit-period tick
  // ------------------------------------------------------------
  acc_tick u_tick (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .SEL(cur_ff.l_cs),
    .RUN(run),
    .RC_CLK(RC_CLK),
    .TICK(tick)
  );
  // ------------------------------------------------------------
  // Pin control
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign DIG_IN_EN[gi] = !asel[gi];
      assign PIN_OE[gi] = !dir[gi];
    end
  endgenerate
  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = cur_ff;
    trial = 10'h000;
    kept = 10'h000;
    if (WR) begin
      case (ADDR)
        ADDR_CTRL0: begin
          nxt_st.justify = WDATA[CTRL0_JUSTIFY];
          nxt_st.ref_sel = WDATA[CTRL0_REFSEL];
          nxt_st.chan = WDATA[CTRL0_CHAN_HI:CTRL0_CHAN_LO];
          nxt_st.go = WDATA[CTRL0_GO];
          nxt_st.on = WDATA[CTRL0_ON];
        end
        ADDR_CTRL1: nxt_st.cs = WDATA[CTRL1_CS_HI:CTRL1_CS_LO];
        ADDR_ASEL_LO: nxt_st.asel_lo = WDATA;
        ADDR_ASEL_HI: nxt_st.asel_hi = WDATA[3:0];
        ADDR_DIR_LO: nxt_st.dir_lo = WDATA;
        ADDR_DIR_HI: nxt_st.dir_hi = WDATA[3:0];
        ADDR_STATUS: nxt_st.done_flag = WDATA[0];
        ADDR_INT_EN: nxt_st.int_en = WDATA[0];
        default: ;
      endcase
    end
    case (cur_ff.st)
      ST_IDLE, ST_ACQ: begin
        // Selections are latched only while idle or acquiring
        nxt_st.l_chan = cur_ff.chan;
        nxt_st.l_ref = cur_ff.ref_sel;
        nxt_st.l_cs = cur_ff.cs;
        if (cur_ff.go && cur_ff.on) begin
          nxt_st.st = ST_CONV;
          nxt_st.sar = 10'h000;
          nxt_st.bitn = 4'h0;
        end
      end
      ST_CONV: begin
        if (!cur_ff.go) begin
          // Aborted: result is left untouched
          nxt_st.st = ST_WAIT;
          nxt_st.per = 4'h0;
        end else if (tick) begin
          nxt_st.bitn = cur_ff.bitn + 4'h1;
          // Period 0 samples and offers the MSB; periods 1..10 keep or
          // drop the bit on trial and offer the next one, so the DAC
          // always shows the very code that the comparator judges
          if (cur_ff.bitn == 4'h0) begin
            nxt_st.sar = 10'h200;
          end else begin
            trial = 10'h200 >> (cur_ff.bitn - 4'h1);
            kept = CMP_IN ? cur_ff.sar : (cur_ff.sar & ~trial);
            nxt_st.sar = kept | (trial >> 1);
          end
          if (cur_ff.bitn == CONV_PERIODS - 4'h1) begin
            nxt_st.st = ST_ACQ;
            nxt_st.result = kept;
            nxt_st.go = 1'b0;
            nxt_st.done_flag = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          nxt_st.per = cur_ff.per + 4'h1;
          if (cur_ff.per == ABORT_PERIODS - 4'h1) begin
            nxt_st.st = ST_ACQ;
          end
        end
      end
      default: nxt_st.st = ST_IDLE;
    endcase
    // Disabling the converter forces it back to idle
    if (!cur_ff.on) begin
      nxt_st.st = ST_IDLE;
    end
    nxt_st.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        ADDR_CTRL0: nxt_st.rdata = {cur_ff.justify, cur_ff.ref_sel,
                                    cur_ff.chan, cur_ff.go, cur_ff.on};
        ADDR_CTRL1: nxt_st.rdata = {1'b0, cur_ff.cs, 4'h0};
        ADDR_RES_HI: nxt_st.rdata = cur_ff.justify ?
          {6'h00, cur_ff.result[9:8]} : cur_ff.result[9:2];
        ADDR_RES_LO: nxt_st.rdata = cur_ff.justify ?
          cur_ff.result[7:0] : {cur_ff.result[1:0], 6'h00};
        ADDR_ASEL_LO: nxt_st.rdata = cur_ff.asel_lo;
        ADDR_ASEL_HI: nxt_st.rdata = {4'h0, cur_ff.asel_hi};
        ADDR_DIR_LO: nxt_st.rdata = cur_ff.dir_lo;
        ADDR_DIR_HI: nxt_st.rdata = {4'h0, cur_ff.dir_hi};
        ADDR_STATUS: nxt_st.rdata = {7'h00, cur_ff.done_flag};
        ADDR_INT_EN: nxt_st.rdata = {7'h00, cur_ff.int_en};
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cur_ff <= '0;
      cur_ff.asel_lo <= ASEL_LO_RST;
      cur_ff.asel_hi <= ASEL_HI_RST;
      cur_ff.dir_lo <= DIR_LO_RST;
      cur_ff.dir_hi <= DIR_HI_RST;
      cur_ff.st <= ST_IDLE;
    end else begin
      cur_ff <= nxt_st;
    end
  end
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign RDATA = cur_ff.rdata;
  assign DAC_CODE = cur_ff.sar;
  assign MUX_SEL = cur_ff.l_chan;
  assign REF_EXT = cur_ff.l_ref;
  assign SAMPLE = (cur_ff.st == ST_IDLE) || (cur_ff.st == ST_ACQ);
  assign IRQ = cur_ff.done_flag && cur_ff.int_en;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // A conversion is a start, ticks while go and on stay high, and a
  // last tick; an abort is a wait of two ticks, each a sequence of its own
  sequence s_start;
    cur_ff.st != ST_CONV ##1 cur_ff.st == ST_CONV;
  endsequence
  sequence s_running;
    cur_ff.st == ST_CONV && cur_ff.go && cur_ff.on;
  endsequence
  sequence s_last_tick;
    s_running ##0 (tick && cur_ff.bitn == CONV_PERIODS - 4'h1);
  endsequence
  sequence s_waiting;
    cur_ff.st == ST_WAIT && cur_ff.on;
  endsequence
  sequence s_done;
    cur_ff.st == ST_CONV && nxt_st.st == ST_ACQ;
  endsequence

  property p_start;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_start |-> cur_ff.bitn == 4'h0 && !SAMPLE;
  endproperty
  a_start: assert property (p_start) else $error("bad start");

  property p_route;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_start |-> MUX_SEL == $past(cur_ff.chan) &&
        REF_EXT == $past(cur_ff.ref_sel) &&
        cur_ff.l_cs == $past(cur_ff.cs);
  endproperty
  a_route: assert property (p_route) else $error("route bad");

  property p_eleven;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_running ##0 !(tick && cur_ff.bitn == CONV_PERIODS - 4'h1)
        |=> cur_ff.st == ST_CONV;
  endproperty
  a_eleven: assert property (p_eleven) else $error("short conv");

  property p_last;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_last_tick |=> cur_ff.st == ST_ACQ && cur_ff.bitn == CONV_PERIODS;
  endproperty
  a_last: assert property (p_last) else $error("long conv");

  property p_step;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_running |=>
        cur_ff.bitn == $past(cur_ff.bitn) + {3'h0, $past(tick)};
  endproperty
  a_step: assert property (p_step) else $error("tick count");

  property p_done;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_done |=> !cur_ff.go && cur_ff.done_flag && cur_ff.bitn == 4'hB;
  endproperty
  a_done: assert property (p_done) else $error("done bad");

  property p_abort;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (cur_ff.st == ST_WAIT) |=> $stable(cur_ff.result);
  endproperty
  a_abort: assert property (p_abort) else $error("abort result");

  property p_abort_go;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (cur_ff.st == ST_CONV && !cur_ff.go && cur_ff.on)
        |=> cur_ff.st == ST_WAIT && $stable(cur_ff.result);
  endproperty
  a_abort_go: assert property (p_abort_go) else $error("no wait");

  property p_wait2;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_waiting ##0 (tick && cur_ff.per == ABORT_PERIODS - 4'h1)
        |=> cur_ff.st == ST_ACQ && SAMPLE;
  endproperty
  a_wait2: assert property (p_wait2) else $error("no reacquire");

  property p_wait_hold;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_waiting ##0 !(tick && cur_ff.per == ABORT_PERIODS - 4'h1)
        |=> cur_ff.st == ST_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("early");

  property p_sar_first;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_running ##0 (tick && cur_ff.bitn == 4'h0) |=> DAC_CODE == 10'h200;
  endproperty
  a_sar_first: assert property (p_sar_first) else $error("msb");

  property p_result;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_done |=> cur_ff.result == DAC_CODE;
  endproperty
  a_result: assert property (p_result) else $error("result bad");

  property p_irq;
    @(posedge CLK_SYS) disable iff (!RST_N)
      s_done ##0 (cur_ff.int_en && !(WR && ADDR == ADDR_INT_EN)) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq bad");

  property p_lock;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (cur_ff.st == ST_CONV) ##1 (cur_ff.st == ST_CONV)
        |-> $stable(MUX_SEL) && $stable(REF_EXT) && $stable(cur_ff.l_cs);
  endproperty
  a_lock: assert property (p_lock) else $error("sel changed");
  property p_dig;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (DIG_IN_EN & asel) == 12'h000;
  endproperty
  a_dig: assert property (p_dig) else $error("buffer on");
  property p_oe;
    @(posedge CLK_SYS) disable iff (!RST_N) (PIN_OE & dir) == 12'h000;
  endproperty
  a_oe: assert property (p_oe) else $error("driver on");
  property p_rdj;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (RD && ADDR == ADDR_RES_HI && cur_ff.justify)
        |=> RDATA[7:2] == 6'h00;
  endproperty
  a_rdj: assert property (p_rdj) else $error("justify bad");

  property p_rdl;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (RD && ADDR == ADDR_RES_LO && !cur_ff.justify)
        |=> RDATA[5:0] == 6'h00;
  endproperty
  a_rdl: assert property (p_rdl) else $error("left justify bad");

  property p_asel_wr;
    @(posedge CLK_SYS) disable iff (!RST_N)
      (WR && ADDR == ADDR_ASEL_HI)
        |=> {4'h0, cur_ff.asel_hi} == ($past(WDATA) & 8'h0F);
  endproperty
  a_asel_wr: assert property (p_asel_wr) else $error("asel hi");
endmodule // acc_top
`default_nettype wire

// File: verification/tb_acc_top.sv
// Self-checking bench for the converter control block.
// Assumes acc_pkg and acc_top are compiled first; the bench drives all ports.
`default_nettype none
module tb_acc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  // ----------------------------------------
  // Signals and device
  // ----------------------------------------
  logic clk_sys, rst_n, wr_s, rd_s, rc_clk, cmp_in;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [9:0] dac_code, tgt;
  logic [3:0] mux_sel;
  logic ref_ext, sample, irq;
  logic [11:0] dig_in_en, pin_oe;
  int checks = 0;
  int miscompares = 0;
  int cyc = 0;
  int per_tab [8] = '{2, 8, 32, 6, 4, 16, 64, 6};
  acc_top dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .RC_CLK(rc_clk),
    .CMP_IN(cmp_in), .DAC_CODE(dac_code), .MUX_SEL(mux_sel),
    .REF_EXT(ref_ext), .SAMPLE(sample), .DIG_IN_EN(dig_in_en),
    .PIN_OE(pin_oe), .IRQ(irq));
  // ----------------------------------------
  // Clock, analog stand-ins, timeout
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Comparator lags the trial code by a cycle; fine for periods of 2 or more
  always @(posedge clk_sys) begin
    cyc++;
    rc_clk <= (cyc % 6) < 3;
    cmp_in <= (tgt >= dac_code);
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk_sys);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic conv(input logic [2:0] cs, input logic [7:0] c0,
                      output int n);
    wr(ADDR_CTRL1, {1'b0, cs, 4'h0});
    wr(ADDR_CTRL0, c0);
    // Go is acted on one edge after the write lands
    @(posedge clk_sys);
    #1;
    chk(12'(sample), 12'h0);
    chk(12'(mux_sel), 12'(c0[5:2]));
    chk(12'(ref_ext), 12'(c0[6]));
    n = 0;
    while (sample !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n, p;
    logic [2:0] cs;
    logic [3:0] ch;
    logic ie, ok;
    logic [7:0] eh, el;
    rst_n = 1'b0; addr = 4'h0; wdata = 8'h00; wr_s = 1'b0; rd_s = 1'b0;
    tgt = 10'h000;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_ASEL_LO, d); chk(12'(d), 12'h0FF);
    rd(ADDR_ASEL_HI, d); chk(12'(d), 12'h00F);
    rd(ADDR_DIR_LO, d); chk(12'(d), 12'h0FF);
    chk(dig_in_en, 12'h000);
    chk(pin_oe, 12'h000);
    wr(ADDR_ASEL_LO, 8'h5A);
    wr(ADDR_ASEL_HI, 8'hF3);
    wr(ADDR_DIR_LO, 8'hC3);
    wr(ADDR_DIR_HI, 8'hA6);
    #1 chk(dig_in_en, 12'hCA5);
    chk(pin_oe, 12'h93C);
    rd(ADDR_ASEL_HI, d); chk(12'(d), 12'h003);
    rd(4'hF, d); chk(12'(d), 12'h000);
    wr(ADDR_RES_LO, 8'h55);
    rd(ADDR_RES_LO, d); chk(12'(d), 12'h000);
    // Every clock-select code, alternating justify and reference
    for (int i = 0; i < 8; i++) begin
      cs = i[2:0];
      ch = 4'(i + 5);
      p = per_tab[i];
      tgt = 10'h3A7 - 10'(i * 91);
      ie = (i != 2);
      wr(ADDR_INT_EN, {7'h00, ie});
      conv(cs, {cs[0], cs[1], ch, 2'b11}, n);
      if (cs[1:0] == 2'b11) ok = (n >= 60 && n <= 74);
      else ok = (n >= 11 * p && n <= 11 * p + 2);
      chk(12'(ok), 12'h001);
      chk(12'(irq), 12'(ie));
      rd(ADDR_STATUS, d); chk(12'(d[0]), 12'h001);
      rd(ADDR_CTRL0, d); chk(12'(d), 12'({cs[0], cs[1], ch, 2'b01}));
      eh = cs[0] ? {6'h00, tgt[9:8]} : tgt[9:2];
      el = cs[0] ? tgt[7:0] : {tgt[1:0], 6'h00};
      rd(ADDR_RES_HI, d); chk(12'(d), 12'(eh));
      rd(ADDR_RES_LO, d); chk(12'(d), 12'(el));
      wr(ADDR_STATUS, 8'h00);
      #1 chk(12'(irq), 12'h000);
    end
    // Selection change mid-run, then abort
    tgt = 10'h155;
    wr(ADDR_CTRL1, {1'b0, CS_DIV64, 4'h0});
    wr(ADDR_CTRL0, 8'h8B);
    repeat (100) @(posedge clk_sys);
    wr(ADDR_CTRL0, 8'hD7);
    #1 chk(12'(mux_sel), 12'h002);
    chk(12'(ref_ext), 12'h000);
    repeat (100) @(posedge clk_sys);
    wr(ADDR_CTRL0, 8'hD5);
    repeat (40) @(posedge clk_sys);
    #1 chk(12'(sample), 12'h000);
    repeat (192) @(posedge clk_sys);
    #1 chk(12'(sample), 12'h001);
    chk(12'(mux_sel), 12'h005);
    rd(ADDR_RES_HI, d); chk(12'(d), 12'(eh));
    rd(ADDR_RES_LO, d); chk(12'(d), 12'(el));
    rd(ADDR_STATUS, d); chk(12'(d[0]), 12'h000);
    tally_and_finish();
  end
endmodule // tb_acc_top
`default_nettype wire
